/* File: core/osc_defs.svh */
// Constants for the tile OTP and security configuration block
`ifndef OSC_DEFS_SVH
`define OSC_DEFS_SVH

// Array geometry: four sectors of 512 rows, 32 bits per row
`define OSC_ROWS_PER_SECTOR 512
`define OSC_SECTORS         4
`define OSC_WORD_BITS       32
`define OSC_ADDR_BITS       12
`define OSC_SPARE_ROWS      8
// Row holding the security configuration image
`define OSC_SEC_ROW         12'h800
`define OSC_LAST_ROW        11'h7ff

// Security configuration bit positions
`define OSC_B_NO_DEBUG      0
`define OSC_B_NO_LINK       1
`define OSC_B_SECURE_BOOT   5
`define OSC_B_REDUNDANT     7
`define OSC_B_SECTOR_LOCK0  8
`define OSC_B_MASTER_LOCK   12
`define OSC_B_NO_DEBUG_OTP  13
`define OSC_B_NO_SYNC_PIN   14
`define OSC_GP_HI           21
`define OSC_GP_LO           15
`define OSC_UID_HI          31
`define OSC_UID_LO          22
`define OSC_SEC_RESET       32'h0000_0000

// Control port bits
`define OSC_CTRL_PROG       0
`define OSC_CTRL_READ       1
`define OSC_CTRL_CLR_REJ    2

// Processor resource numbers of the programming ports
`define OSC_RES_ADDR_PORT   24'h100200
`define OSC_RES_DATA_PORT   24'h200100
`define OSC_RES_CTRL_PORT   24'h100300

// Boot entry points
`define OSC_BOOT_OTP_ADDR   32'h0000_0000
`define OSC_BOOT_ROM_ADDR   32'h0000_0100

`endif

/* File: core/osc_pkg.sv */
// Types shared by the OTP security configuration modules
`default_nettype none
package osc_pkg;
  typedef enum logic [3:0] {
    ST_LOAD  = 4'b0001,
    ST_LWAIT = 4'b0010,
    ST_COPY  = 4'b0100,
    ST_RUN   = 4'b1000
  } osc_state_t;

  typedef enum logic [1:0] {
    OWN_NONE  = 2'b00,
    OWN_PORT  = 2'b01,
    OWN_DEBUG = 2'b10
  } osc_owner_t;

  typedef logic [11:0] osc_addr_t;
  typedef logic [31:0] osc_word_t;
endpackage
`default_nettype wire

/* File: core/osc_array_if.sv */
// Connection between the controller and the OTP array
`default_nettype none
interface osc_array_if;
  import osc_pkg::*;
  logic       rd_en;
  osc_addr_t  rd_addr;
  osc_word_t  rd_data;
  logic       pg_en;
  osc_addr_t  pg_addr;
  osc_word_t  pg_data;
  logic       redund_en;

  modport ctrl (output rd_en, output rd_addr, input rd_data, output pg_en,
                output pg_addr, output pg_data, output redund_en);
  modport mem  (input rd_en, input rd_addr, output rd_data, input pg_en,
                input pg_addr, input pg_data, input redund_en);
endinterface
`default_nettype wire

/* File: core/osc_otp_array.sv */
// One-time programmable array with spare rows and the security row
`default_nettype none
`include "osc_defs.svh"
module osc_otp_array #(
  parameter int ROWS  = `OSC_ROWS_PER_SECTOR * `OSC_SECTORS,
  parameter int SPARE = `OSC_SPARE_ROWS
) (
  input  wire logic sys_clk,
  osc_array_if.mem  bus
);
  import osc_pkg::*;

  // Last entry is the security configuration row; unprogrammed cells read as zero
  osc_word_t mem   [0:ROWS]    = '{default: '0};
  osc_word_t spare [0:SPARE-1] = '{default: '0};

  // Programming can only set bits, never clear them
  always_ff @(posedge sys_clk) begin
    if (bus.pg_en) begin
      mem[bus.pg_addr] <= mem[bus.pg_addr] | bus.pg_data;
      if (bus.redund_en) begin
        spare[bus.pg_addr[$clog2(SPARE)-1:0]] <= spare[bus.pg_addr[$clog2(SPARE)-1:0]]
                                                | bus.pg_data;
      end
    end
  end

  // Spare row copies mask cells stuck at zero
  always_ff @(posedge sys_clk) begin
    if (bus.rd_en) begin
      if (bus.redund_en) begin
        bus.rd_data <= mem[bus.rd_addr] | spare[bus.rd_addr[$clog2(SPARE)-1:0]];
      end else begin
        bus.rd_data <= mem[bus.rd_addr];
      end
    end
  end
endmodule
`default_nettype wire

/* File: core/osc_security_config.sv */
// Tile OTP controller with the power-up loaded security configuration
//
// Functional notes
// - Security bit 0 blocks debug access to tile.
// - Security bit 1 blocks link access from tiles.
// - Security bit 5 boots from OTP address zero.
// - Security bit 7 enables redundant OTP rows.
// - Bits 8-11 lock programming of sectors 0-3.
// - Bit 12 blocks all programming, security row too.
// - Bit 13 denies debug reads and writes of OTP.
// - Bit 14 disables the debug synchronisation pin.
// - Bits 21-15 are readable general purpose storage.
// - Bits 31-22 extend the debug user code.
// - OTP is four sectors of 512 32-bit rows.
// - Security row is loaded before settings apply.
// - Remaining OTP is copied to SRAM at start.
// - Usercode top field returns security bits 31-22.
// - Output mode drives sync pin low at breakpoint.
// - Input mode low sync pin enters debug mode.
// - Secure boot reads image from OTP address zero.
`default_nettype none
`include "osc_defs.svh"
module osc_security_config #(
  parameter int        ROWS_PER_SECTOR = `OSC_ROWS_PER_SECTOR,
  parameter int        SECTORS         = `OSC_SECTORS,
  parameter int        SPARE_ROWS      = `OSC_SPARE_ROWS,
  // Arbitrary revision value for the usercode low field
  parameter bit [21:0] SILICON_REV     = 22'h000123
) (
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  // Processor programming ports
  input  wire logic               port_addr_we,
  input  wire logic [15:0]        port_addr,
  input  wire logic               port_data_we,
  input  wire logic [31:0]        port_data,
  input  wire logic               port_ctrl_we,
  input  wire logic [15:0]        port_ctrl,
  output logic [31:0]             port_rd_data,
  output logic                    port_rd_valid,
  output logic                    port_done,
  output logic                    prog_rejected,
  // Debug side OTP access
  input  wire logic               dbg_otp_req,
  input  wire logic               dbg_otp_we,
  input  wire logic [15:0]        dbg_otp_addr,
  input  wire logic [31:0]        dbg_otp_wdata,
  output logic [31:0]             dbg_otp_rdata,
  output logic                    dbg_otp_valid,
  output logic                    dbg_otp_denied,
  // Debug access to tile state and memory
  input  wire logic               dbg_tile_req,
  output logic                    dbg_tile_grant,
  // Link access from other tiles
  input  wire logic               link_req,
  output logic                    link_grant,
  // Debug synchronisation pin
  input  wire logic               dbg_pin_out_mode,
  input  wire logic               dbg_pin_in_mode,
  input  wire logic               breakpoint_hit,
  input  wire logic               sync_n_in,
  output logic                    sync_n_out,
  output logic                    sync_n_oe_n,
  output logic                    debug_mode_req,
  // Startup copy into SRAM and boot control
  output logic                    sram_we,
  output logic [10:0]             sram_addr,
  output logic [31:0]             sram_wdata,
  output logic                    boot_start,
  output logic                    boot_from_otp,
  output logic [31:0]             boot_vector,
  // Configuration views
  output logic [31:0]             security_configuration,
  output logic [6:0]              gp_field,
  output logic [31:0]             usercode,
  output logic                    redundant_en,
  output logic                    config_valid
);
  import osc_pkg::*;

  localparam int ROWS = ROWS_PER_SECTOR * SECTORS;

  osc_array_if arr ();

  osc_state_t state;
  osc_owner_t rd_owner;
  osc_word_t  sec;
  logic [15:0] addr_hold;
  logic [31:0] data_hold;
  logic [10:0] copy_addr;
  logic        copy_vld;
  logic [10:0] copy_prev;
  logic        copy_last;
  logic        run;

  // Requests taken this cycle
  logic port_prog;
  logic port_read;
  logic dbg_take;
  logic dbg_block;
  logic next_prog_en;
  logic [15:0] next_prog_addr;
  logic [31:0] next_prog_data;
  logic        prog_ok;
  logic        next_rd_en;
  logic [15:0] next_rd_addr;

  assign run = (state == ST_RUN);

  // Checks whether a row may still be programmed
  function automatic logic may_program(input logic [15:0] a, input osc_word_t s);
    logic ok;
    ok = 1'b0;
    if (s[`OSC_B_MASTER_LOCK]) begin
      ok = 1'b0;
    end else if (a == 16'(`OSC_SEC_ROW)) begin
      ok = 1'b1;
    end else if (a < 16'(ROWS)) begin
      ok = !s[`OSC_B_SECTOR_LOCK0 + int'(a[10:9])];
    end
    return ok;
  endfunction

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_hold <= 16'h0000;
      data_hold <= 32'h0000_0000;
    end else begin
      if (port_addr_we) begin
        addr_hold <= port_addr;
      end
      if (port_data_we) begin
        data_hold <= port_data;
      end
    end
  end

  assign dbg_block = sec[`OSC_B_NO_DEBUG_OTP] | sec[`OSC_B_NO_DEBUG];
  assign port_prog = run && port_ctrl_we && port_ctrl[`OSC_CTRL_PROG];
  assign port_read = run && port_ctrl_we && port_ctrl[`OSC_CTRL_READ] && !port_prog;
  assign dbg_take  = run && dbg_otp_req && !port_ctrl_we;

  always_comb begin
    next_prog_en   = 1'b0;
    next_prog_addr = addr_hold;
    next_prog_data = data_hold;
    next_rd_en     = 1'b0;
    next_rd_addr   = addr_hold;
    if (state == ST_LOAD) begin
      next_rd_en   = 1'b1;
      next_rd_addr = 16'(`OSC_SEC_ROW);
    end else if (state == ST_COPY) begin
      next_rd_en   = 1'b1;
      next_rd_addr = {5'h00, copy_addr};
    end else if (port_prog) begin
      next_prog_en = 1'b1;
    end else if (port_read) begin
      next_rd_en = 1'b1;
    end else if (dbg_take && !dbg_block) begin
      next_prog_en   = dbg_otp_we;
      next_prog_addr = dbg_otp_addr;
      next_prog_data = dbg_otp_wdata;
      next_rd_en     = !dbg_otp_we;
      next_rd_addr   = dbg_otp_addr;
    end
  end

  assign prog_ok = may_program(next_prog_addr, sec);

  // array only ORs in new ones
  assign arr.pg_en     = next_prog_en && prog_ok;
  assign arr.pg_addr   = next_prog_addr[11:0];
  assign arr.pg_data   = next_prog_data;
  assign arr.rd_en     = next_rd_en;
  assign arr.rd_addr   = (next_rd_addr < 16'(ROWS) || next_rd_addr == 16'(`OSC_SEC_ROW))
                         ? next_rd_addr[11:0] : `OSC_SEC_ROW;
  assign arr.redund_en = sec[`OSC_B_REDUNDANT];

  osc_otp_array #(
    .ROWS  (ROWS),
    .SPARE (SPARE_ROWS)
  ) u_array (
    .sys_clk (sys_clk),
    .bus     (arr)
  );

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_LOAD;
    end else begin
      case (state)
        ST_LOAD: begin
          state <= ST_LWAIT;
        end
        ST_LWAIT: begin
          state <= ST_COPY;
        end
        ST_COPY: begin
          if (copy_last) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          state <= ST_RUN;
        end
        default: begin
          state <= ST_LOAD;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sec <= `OSC_SEC_RESET;
    end else if (state == ST_LWAIT) begin
      sec <= arr.rd_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      copy_addr <= 11'h000;
      copy_vld  <= 1'b0;
      copy_prev <= 11'h000;
      copy_last <= 1'b0;
      sram_we   <= 1'b0;
      sram_addr <= 11'h000;
      sram_wdata <= 32'h0000_0000;
    end else begin
      copy_vld  <= (state == ST_COPY) && !copy_last;
      copy_prev <= copy_addr;
      sram_we   <= copy_vld;
      sram_addr <= copy_prev;
      sram_wdata <= arr.rd_data;
      if (state == ST_COPY && !copy_last) begin
        copy_addr <= copy_addr + 11'h001;
        copy_last <= (copy_addr == `OSC_LAST_ROW);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_start    <= 1'b0;
      boot_from_otp <= 1'b0;
      boot_vector   <= `OSC_BOOT_ROM_ADDR;
      config_valid  <= 1'b0;
    end else begin
      boot_start   <= run && sram_we;
      config_valid <= (state != ST_LOAD) && (state != ST_LWAIT);
      if (state == ST_COPY) begin
        boot_from_otp <= sec[`OSC_B_SECURE_BOOT];
        boot_vector   <= sec[`OSC_B_SECURE_BOOT] ? `OSC_BOOT_OTP_ADDR : `OSC_BOOT_ROM_ADDR;
      end
    end
  end

  // Read return routing and status
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_owner       <= OWN_NONE;
      port_rd_data   <= 32'h0000_0000;
      port_rd_valid  <= 1'b0;
      port_done      <= 1'b0;
      dbg_otp_rdata  <= 32'h0000_0000;
      dbg_otp_valid  <= 1'b0;
      dbg_otp_denied <= 1'b0;
    end else begin
      port_rd_valid  <= (rd_owner == OWN_PORT);
      dbg_otp_valid  <= (rd_owner == OWN_DEBUG) || (dbg_take && !dbg_block && dbg_otp_we);
      port_done      <= port_prog || port_read;
      dbg_otp_denied <= dbg_take && dbg_block;
      if (rd_owner == OWN_PORT) begin
        port_rd_data <= arr.rd_data;
      end
      if (rd_owner == OWN_DEBUG) begin
        dbg_otp_rdata <= arr.rd_data;
      end
      if (port_read) begin
        rd_owner <= OWN_PORT;
      end else if (!port_prog && dbg_take && !dbg_block && !dbg_otp_we) begin
        rd_owner <= OWN_DEBUG;
      end else begin
        rd_owner <= OWN_NONE;
      end
    end
  end

  // sticky reject flag, set wins over clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_rejected <= 1'b0;
    end else if (next_prog_en && !prog_ok) begin
      prog_rejected <= 1'b1;
    end else if (port_ctrl_we && port_ctrl[`OSC_CTRL_CLR_REJ]) begin
      prog_rejected <= 1'b0;
    end
  end

  // Access grants
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dbg_tile_grant <= 1'b0;
      link_grant     <= 1'b0;
    end else begin
      dbg_tile_grant <= run && dbg_tile_req && !sec[`OSC_B_NO_DEBUG];
      link_grant     <= run && link_req && !sec[`OSC_B_NO_LINK];
    end
  end

  // Debug synchronisation pin
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_n_out     <= 1'b0;
      sync_n_oe_n    <= 1'b1;
      debug_mode_req <= 1'b0;
    end else begin
      sync_n_out     <= 1'b0;
      sync_n_oe_n    <= !(run && !sec[`OSC_B_NO_SYNC_PIN] && dbg_pin_out_mode
                          && breakpoint_hit);
      debug_mode_req <= run && !sec[`OSC_B_NO_SYNC_PIN] && dbg_pin_in_mode
                        && !dbg_pin_out_mode && !sync_n_in;
    end
  end

  // Configuration views
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      security_configuration <= `OSC_SEC_RESET;
      gp_field               <= 7'h00;
      usercode               <= 32'h0000_0000;
      redundant_en           <= 1'b0;
    end else begin
      security_configuration <= sec;
      gp_field     <= sec[`OSC_GP_HI:`OSC_GP_LO];
      usercode     <= {sec[`OSC_UID_HI:`OSC_UID_LO], SILICON_REV};
      redundant_en <= sec[`OSC_B_REDUNDANT];
    end
  end
endmodule
`default_nettype wire

/* File: testbench/osc_sync_host.sv */
// Far side of the debug sync pin: pull-up plus an external agent
`default_nettype none
module osc_sync_host (
  input  wire logic sync_n_out,
  input  wire logic sync_n_oe_n,
  input  wire logic host_pull_low,
  output logic      sync_n_in
);
  timeunit 1ns;
  timeprecision 1ns;
  assign sync_n_in = host_pull_low ? 1'b0 : (sync_n_oe_n ? 1'b1 : sync_n_out);
endmodule
`default_nettype wire

/* File: testbench/osc_security_config_assertions.sv */
// Port level assertions for the OTP security configuration block
`default_nettype none
module osc_security_config_assertions (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        port_ctrl_we,
  input wire logic [15:0] port_ctrl,
  input wire logic        port_done,
  input wire logic        prog_rejected,
  input wire logic        dbg_otp_req,
  input wire logic        dbg_otp_valid,
  input wire logic        dbg_otp_denied,
  input wire logic        dbg_tile_req,
  input wire logic        dbg_tile_grant,
  input wire logic        link_req,
  input wire logic        link_grant,
  input wire logic        dbg_pin_out_mode,
  input wire logic        dbg_pin_in_mode,
  input wire logic        breakpoint_hit,
  input wire logic        sync_n_in,
  input wire logic        sync_n_out,
  input wire logic        sync_n_oe_n,
  input wire logic        debug_mode_req,
  input wire logic        boot_start,
  input wire logic        boot_from_otp,
  input wire logic [31:0] boot_vector,
  input wire logic [31:0] security_configuration,
  input wire logic [6:0]  gp_field,
  input wire logic [31:0] usercode
);
  logic run_seen;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Requests count only once start-up has finished
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      run_seen <= 1'b0;
    else if (boot_start)
      run_seen <= 1'b1;
  end
  tile_grant_a:
    assert property (run_seen |=> dbg_tile_grant == $past(dbg_tile_req &&
      !security_configuration[0])) else $error("tile grant wrong");
  link_grant_a:
    assert property (run_seen |=> link_grant == $past(link_req && !security_configuration[1]))
      else $error("link grant wrong");
  otp_deny_a:
    assert property (run_seen && dbg_otp_req && !port_ctrl_we && (security_configuration[13] ||
      security_configuration[0]) |=> dbg_otp_denied) else $error("debug otp not denied");
  otp_silent_a:
    assert property (run_seen && security_configuration[13] |-> !dbg_otp_valid)
      else $error("debug otp answered while blocked");
  sync_drive_a:
    assert property (run_seen |=> !sync_n_out && sync_n_oe_n == !$past(dbg_pin_out_mode &&
      breakpoint_hit && !security_configuration[14])) else $error("sync pin drive wrong");
  debug_entry_a:
    assert property (run_seen |=> debug_mode_req == $past(dbg_pin_in_mode && !dbg_pin_out_mode
      && !sync_n_in && !security_configuration[14])) else $error("debug entry wrong");
  gp_view_a:
    assert property (run_seen |-> gp_field == security_configuration[21:15])
      else $error("gp field mismatch");
  user_id_a:
    assert property (run_seen |-> usercode[31:22] == security_configuration[31:22])
      else $error("usercode id mismatch");
  boot_vector_a:
    assert property (run_seen |-> boot_from_otp == security_configuration[5] && boot_vector ==
      (security_configuration[5] ? 32'h0 : 32'h100)) else $error("boot vector wrong");
  done_pulse_a:
    assert property (run_seen && port_ctrl_we && port_ctrl[1:0] != 2'h0 |=> port_done)
      else $error("port done missing");
  master_lock_a:
    assert property (run_seen && port_ctrl_we && port_ctrl[0] && security_configuration[12]
      |=> prog_rejected) else $error("locked program not refused");
endmodule
bind osc_security_config osc_security_config_assertions u_osc_security_config_assertions (
  .sys_clk, .rst_n, .port_ctrl_we, .port_ctrl, .port_done, .prog_rejected, .dbg_otp_req,
  .dbg_otp_valid, .dbg_otp_denied, .dbg_tile_req, .dbg_tile_grant, .link_req, .link_grant,
  .dbg_pin_out_mode, .dbg_pin_in_mode, .breakpoint_hit, .sync_n_in, .sync_n_out, .sync_n_oe_n,
  .debug_mode_req, .boot_start, .boot_from_otp, .boot_vector, .security_configuration,
  .gp_field, .usercode);
`default_nettype wire

/* File: testbench/osc_security_config_tb_top.sv */
// Self-checking bench for the OTP security configuration block
`default_nettype none
module osc_security_config_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam bit [21:0] REV = 22'h000123;
  logic        sys_clk, rst_n, port_addr_we, port_data_we, port_ctrl_we, port_rd_valid;
  logic        port_done, prog_rejected, dbg_otp_req, dbg_otp_we, dbg_otp_valid;
  logic        dbg_otp_denied, dbg_tile_req, dbg_tile_grant, link_req, link_grant;
  logic        dbg_pin_out_mode, dbg_pin_in_mode, breakpoint_hit, sync_n_in, sync_n_out;
  logic        sync_n_oe_n, debug_mode_req, sram_we, boot_start, boot_from_otp;
  logic        redundant_en, config_valid, host_pull_low;
  logic [15:0] port_addr, port_ctrl, dbg_otp_addr, row;
  logic [31:0] port_data, port_rd_data, dbg_otp_wdata, dbg_otp_rdata, sram_wdata;
  logic [31:0] boot_vector, security_configuration, usercode, sec_img, rd_word, w1;
  logic [10:0] sram_addr;
  logic [6:0]  gp_field;
  int          bad_count, compares, cycles;

  osc_security_config #(.SILICON_REV(REV)) u_osc_security_config (
    .sys_clk, .rst_n, .port_addr_we, .port_addr, .port_data_we, .port_data, .port_ctrl_we,
    .port_ctrl, .port_rd_data, .port_rd_valid, .port_done, .prog_rejected, .dbg_otp_req,
    .dbg_otp_we, .dbg_otp_addr, .dbg_otp_wdata, .dbg_otp_rdata, .dbg_otp_valid,
    .dbg_otp_denied, .dbg_tile_req, .dbg_tile_grant, .link_req, .link_grant,
    .dbg_pin_out_mode, .dbg_pin_in_mode, .breakpoint_hit, .sync_n_in, .sync_n_out,
    .sync_n_oe_n, .debug_mode_req, .sram_we, .sram_addr, .sram_wdata, .boot_start,
    .boot_from_otp, .boot_vector, .security_configuration, .gp_field, .usercode,
    .redundant_en, .config_valid);
  osc_sync_host u_osc_sync_host (.sync_n_out, .sync_n_oe_n, .host_pull_low, .sync_n_in);

  always #25 sys_clk = ~sys_clk;

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  function automatic logic [31:0] exp_user(input logic [31:0] s);
    return {s[31:22], REV};
  endfunction

  task automatic port_op(input logic [15:0] a, input logic [31:0] d, input logic [15:0] c,
                         input logic rej);
    port_addr_we = 1'b1;
    port_addr = a;
    @(negedge sys_clk);
    port_addr_we = 1'b0;
    port_data_we = 1'b1;
    port_data = d;
    @(negedge sys_clk);
    port_data_we = 1'b0;
    port_ctrl_we = 1'b1;
    port_ctrl = c;
    @(negedge sys_clk);
    port_ctrl_we = 1'b0;
    chk("done", {31'h0, port_done}, {31'h0, c[0] | c[1]});
    chk("reject", {31'h0, prog_rejected}, {31'h0, rej});
    if (c[1]) begin
      @(negedge sys_clk);
      chk("rd_valid", {31'h0, port_rd_valid}, 32'h1);
      rd_word = port_rd_data;
    end
  endtask

  task automatic dbg_op(input logic we, input logic [15:0] a, input logic [31:0] d,
                        input logic deny);
    dbg_otp_req = 1'b1;
    dbg_otp_we = we;
    dbg_otp_addr = a;
    dbg_otp_wdata = d;
    @(negedge sys_clk);
    dbg_otp_req = 1'b0;
    chk("denied", {31'h0, dbg_otp_denied}, {31'h0, deny});
    if (we) chk("dbg_wvalid", {31'h0, dbg_otp_valid}, {31'h0, !deny});
    if (!we && !deny) begin
      @(negedge sys_clk);
      chk("dbg_valid", {31'h0, dbg_otp_valid}, 32'h1);
      rd_word = dbg_otp_rdata;
    end
  endtask

  task automatic boot_up;
    int n;
    int nw;
    n = 0;
    nw = 0;
    rst_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    rst_n = 1'b1;
    while (boot_start !== 1'b1 && n < 5000) begin
      @(negedge sys_clk);
      if (sram_we === 1'b1) begin
        chk("sram_addr", {21'h0, sram_addr}, 32'(nw));
        if (sram_addr === row[10:0]) chk("sram_data", sram_wdata, w1);
        nw++;
      end
      n++;
    end
    chk("copies", 32'(nw), 32'd2048);
    @(negedge sys_clk);
  endtask

  task automatic check_cfg(input logic [31:0] s);
    chk("config", security_configuration, s);
    chk("cfg_valid", {31'h0, config_valid}, 32'h1);
    chk("gp", {25'h0, gp_field}, {25'h0, s[21:15]});
    chk("usercode", usercode, exp_user(s));
    chk("vector", boot_vector, s[5] ? 32'h0 : 32'h100);
    chk("boot_otp", {31'h0, boot_from_otp}, {31'h0, s[5]});
    chk("redund", {31'h0, redundant_en}, {31'h0, s[7]});
    chk("sync_idle", {31'h0, sync_n_in}, 32'h1);
    dbg_tile_req = 1'b1;
    link_req = 1'b1;
    dbg_pin_out_mode = 1'b1;
    breakpoint_hit = 1'b1;
    @(negedge sys_clk);
    chk("tile_grant", {31'h0, dbg_tile_grant}, {31'h0, !s[0]});
    chk("link_grant", {31'h0, link_grant}, {31'h0, !s[1]});
    chk("sync_drive", {31'h0, sync_n_in}, {31'h0, s[14]});
    {dbg_tile_req, link_req, dbg_pin_out_mode, breakpoint_hit} = '0;
    dbg_pin_in_mode = 1'b1;
    host_pull_low = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk("debug_mode", {31'h0, debug_mode_req}, {31'h0, !s[14]});
    dbg_pin_in_mode = 1'b0;
    host_pull_low = 1'b0;
    @(negedge sys_clk);
  endtask

  initial begin
    {sys_clk, rst_n, port_addr_we, port_data_we, port_ctrl_we, dbg_otp_req, dbg_otp_we} = '0;
    {dbg_tile_req, link_req, dbg_pin_out_mode, dbg_pin_in_mode, breakpoint_hit} = '0;
    {host_pull_low, port_addr, port_data, port_ctrl, dbg_otp_addr, dbg_otp_wdata} = '0;
    {bad_count, compares, cycles} = '0;
    {row, w1} = '0;
    void'($urandom(32'h6935));
    boot_up();
    check_cfg(32'h0);
    for (int s = 0; s < 4; s++) begin
      row = {5'h0, s[1:0], 9'($urandom)};
      w1 = $urandom;
      if (s == 3) begin
        dbg_op(1'b1, row, w1, 1'b0);
      end else begin
        port_op(row, w1, 16'h1, 1'b0);
      end
      port_op(row, 32'h0, 16'h2, 1'b0);
      chk("port_rd", rd_word, w1);
      dbg_op(1'b0, row, 32'h0, 1'b0);
      chk("dbg_rd", rd_word, w1);
    end
    port_op(16'h0801, 32'h1, 16'h1, 1'b1);
    port_op(16'h0, 32'h0, 16'h4, 1'b0);
    sec_img = ($urandom & ~32'h1080) | 32'h6123;
    port_op(16'h0800, sec_img, 16'h1, 1'b0);
    port_op(16'h0800, 32'h0, 16'h1, 1'b0);
    port_op(16'h0800, 32'h0, 16'h2, 1'b0);
    chk("sec_row", rd_word, sec_img);
    boot_up();
    check_cfg(sec_img);
    port_op(16'h0010, 32'h5, 16'h1, 1'b1);
    port_op(16'h0, 32'h0, 16'h4, 1'b0);
    dbg_op(1'b0, 16'h0600, 32'h0, 1'b1);
    dbg_op(1'b1, 16'h0600, 32'h7, 1'b1);
    port_op(16'h0800, 32'h1080, 16'h1, 1'b0);
    boot_up();
    check_cfg(sec_img | 32'h1080);
    port_op(16'h0400, 32'h9, 16'h1, 1'b1);
    port_op(16'h0, 32'h0, 16'h4, 1'b0);
    port_op(16'h0800, 32'h8000_0000, 16'h1, 1'b1);
    finish_test();
  end
endmodule
`default_nettype wire
